// ### route_pkg.sv
`default_nettype none
package route_pkg;
  localparam int unsigned NUM_DEST = 8;
  localparam int unsigned NUM_TXQ = 16;
  localparam int unsigned NUM_LSC = 32;
  localparam int unsigned SEL_W = 4;
  localparam int unsigned ADDR_W = 12;

  // register byte offsets
  localparam logic [11:0] TX_ROUTE_LO_OFF = 12'h2d0;
  localparam logic [11:0] TX_ROUTE_HI_OFF = 12'h2d4;
  localparam logic [11:0] LS_ROUTE_0_OFF = 12'h2e0;
  localparam logic [11:0] LS_ROUTE_1_OFF = 12'h2e4;
  localparam logic [11:0] LS_ROUTE_2_OFF = 12'h2e8;
  localparam logic [11:0] LS_ROUTE_3_OFF = 12'h2ec;
  localparam logic [11:0] IRQ_STATUS_OFF = 12'h2f0;
  localparam logic [11:0] IRQ_MASK_OFF = 12'h2f4;
  localparam logic [11:0] DEST_STATE_OFF = 12'h2f8;

  // reset values
  localparam logic [31:0] ROUTE_RESET = 32'h0000_0000;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;

  // selector field layout
  localparam int unsigned SEL_RSV_BIT = 3;
  localparam int unsigned LS_TIMEOUT_BIT = 4;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage : route_pkg
`default_nettype wire

// ### route_steer.sv
`default_nettype none
module route_steer #(
  parameter int unsigned NUM_SRC = 16,
  parameter int unsigned NUM_DEST = 8
) (
  // conditions and selectors
  input wire logic [NUM_SRC-1:0] pending_in,
  input wire logic [NUM_SRC*4-1:0] selector_in,
  // destinations
  output logic [NUM_DEST-1:0] dest_out
);
  // one-hot decode; reserved codes give no line
  function automatic logic [NUM_DEST-1:0] sel_decode(input logic [3:0] sel);
    logic [NUM_DEST-1:0] hot;
    hot = '0;
    if (!sel[route_pkg::SEL_RSV_BIT] && (int'(sel) < NUM_DEST)) begin
      hot[sel[2:0]] = 1'b1;
    end
    return hot;
  endfunction : sel_decode

  logic [NUM_DEST-1:0] contrib [NUM_SRC];

  genvar i;
  generate
    for (i = 0; i < NUM_SRC; i++) begin : g_src
      assign contrib[i] = pending_in[i] ? sel_decode(selector_in[i*4 +: 4]) : '0;
    end
  endgenerate

  always_comb begin
    dest_out = '0;
    for (int k = 0; k < NUM_SRC; k++) begin
      dest_out = dest_out | contrib[k];
    end
  end
endmodule : route_steer
`default_nettype wire

// ### pending_sync.sv
`default_nettype none
module pending_sync #(
  parameter int unsigned WIDTH = 16
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // asynchronous condition bits
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_state_t;

  sync_state_t s_reg;
  sync_state_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.first = async_in;
    s_next.second = s_reg.first;
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sync_out = s_reg.second;
endmodule : pending_sync
`default_nettype wire

// ### queue_interrupt_routing.sv
// Function
// - queue selector codes 0..7 pick destinations
// - pending condition drives its selected destination
// - selectors read/write, reset to zero
// - queues 0-7 low register, 8-15 high
// - four load/store routing registers, same format
// - load/store bit 4 routed by selector 4
//
// The address-and-strobe port was chosen for this implementation.
`default_nettype none
module queue_interrupt_routing #(
  parameter int unsigned NUM_TXQ = route_pkg::NUM_TXQ,
  parameter int unsigned NUM_LSC = route_pkg::NUM_LSC,
  parameter int unsigned NUM_DEST = route_pkg::NUM_DEST
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // register port
  input wire logic [route_pkg::ADDR_W-1:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic write_in,
  input wire logic read_in,
  output logic [31:0] rdata_out,
  // condition status bits from the status registers
  input wire logic [NUM_TXQ-1:0] tx_pending_in,
  input wire logic [NUM_LSC-1:0] ls_pending_in,
  // destination lines and summary interrupt
  output logic [NUM_DEST-1:0] interrupt_destination_out,
  output logic irq_out
);
  typedef struct packed {
    logic [31:0] tx_lo;
    logic [31:0] tx_hi;
    logic [31:0] ls0;
    logic [31:0] ls1;
    logic [31:0] ls2;
    logic [31:0] ls3;
    logic [NUM_DEST-1:0] dest;
    logic [NUM_DEST-1:0] dest_prev;
    logic [NUM_DEST-1:0] status;
    logic [NUM_DEST-1:0] mask;
    logic [31:0] rdata;
  } state_t;

  state_t s_reg;
  state_t s_next;

  logic [NUM_TXQ-1:0] tx_sync;
  logic [NUM_LSC-1:0] ls_sync;
  logic [NUM_DEST-1:0] tx_dest;
  logic [NUM_DEST-1:0] ls_dest;
  logic [NUM_DEST-1:0] rise;
  // per-destination terms
  logic [NUM_DEST-1:0] active;
  logic [NUM_DEST-1:0] kept;
  logic [NUM_DEST-1:0] req;

  // slots of the register port; REG_NONE covers every unmapped address
  typedef enum logic [3:0] {
    REG_TX_LO,
    REG_TX_HI,
    REG_LS_0,
    REG_LS_1,
    REG_LS_2,
    REG_LS_3,
    REG_STATUS,
    REG_MASK,
    REG_DEST,
    REG_NONE
  } reg_sel_t;

  // decoded strobes
  reg_sel_t wr_sel;
  reg_sel_t rd_sel;
  logic status_clear;

  // selector buses in field order, lowest source in the lowest nibble
  logic [NUM_TXQ*route_pkg::SEL_W-1:0] tx_sel_bus;
  logic [NUM_LSC*route_pkg::SEL_W-1:0] ls_sel_bus;

  // one decoder serves both strobes so they cannot disagree on the map
  function automatic reg_sel_t decode_addr(input logic [route_pkg::ADDR_W-1:0] a);
    reg_sel_t sel;
    sel = REG_NONE;
    case (a)
      route_pkg::TX_ROUTE_LO_OFF: begin
        sel = REG_TX_LO;
      end

      route_pkg::TX_ROUTE_HI_OFF: begin
        sel = REG_TX_HI;
      end

      route_pkg::LS_ROUTE_0_OFF: begin
        sel = REG_LS_0;
      end

      route_pkg::LS_ROUTE_1_OFF: begin
        sel = REG_LS_1;
      end

      route_pkg::LS_ROUTE_2_OFF: begin
        sel = REG_LS_2;
      end

      route_pkg::LS_ROUTE_3_OFF: begin
        sel = REG_LS_3;
      end

      route_pkg::IRQ_STATUS_OFF: begin
        sel = REG_STATUS;
      end

      route_pkg::IRQ_MASK_OFF: begin
        sel = REG_MASK;
      end

      route_pkg::DEST_STATE_OFF: begin
        sel = REG_DEST;
      end

      default: begin
        sel = REG_NONE;
      end
    endcase
    return sel;
  endfunction : decode_addr

  // destination-wide fields read back zero-extended
  function automatic logic [31:0] widen(input logic [NUM_DEST-1:0] v);
    logic [31:0] w;
    w = '0;
    w[NUM_DEST-1:0] = v;
    return w;
  endfunction : widen

  // routing words are stored whole, so reserved codes read back as written
  function automatic logic [31:0] slot_word(input reg_sel_t sel, input state_t s);
    logic [31:0] w;
    w = route_pkg::UNMAPPED_READ;
    case (sel)
      REG_TX_LO: begin
        w = s.tx_lo;
      end

      REG_TX_HI: begin
        w = s.tx_hi;
      end

      REG_LS_0: begin
        w = s.ls0;
      end

      REG_LS_1: begin
        w = s.ls1;
      end

      REG_LS_2: begin
        w = s.ls2;
      end

      REG_LS_3: begin
        w = s.ls3;
      end

      default: begin
        w = route_pkg::UNMAPPED_READ;
      end
    endcase
    return w;
  endfunction : slot_word

  // a strobe without a mapped address decodes to REG_NONE
  always_comb begin
    wr_sel = REG_NONE;
    if (write_in) begin
      wr_sel = decode_addr(addr_in);
    end
  end

  // the status clear rides on the read decode
  always_comb begin
    rd_sel = REG_NONE;
    if (read_in) begin
      rd_sel = decode_addr(addr_in);
    end
  end

  assign status_clear = (rd_sel == REG_STATUS);
  assign tx_sel_bus = {s_reg.tx_hi, s_reg.tx_lo};
  assign ls_sel_bus = {s_reg.ls3, s_reg.ls2, s_reg.ls1, s_reg.ls0};

  // status bits arrive from another block; synchronised for safety
  pending_sync #(
    .WIDTH(NUM_TXQ)
  ) u_tx_sync (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .async_in(tx_pending_in),
    .sync_out(tx_sync)
  );

  pending_sync #(
    .WIDTH(NUM_LSC)
  ) u_ls_sync (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .async_in(ls_pending_in),
    .sync_out(ls_sync)
  );

  route_steer #(
    .NUM_SRC(NUM_TXQ),
    .NUM_DEST(NUM_DEST)
  ) u_tx_steer (
    .pending_in(tx_sync),
    .selector_in(tx_sel_bus),
    .dest_out(tx_dest)
  );

  route_steer #(
    .NUM_SRC(NUM_LSC),
    .NUM_DEST(NUM_DEST)
  ) u_ls_steer (
    .pending_in(ls_sync),
    .selector_in(ls_sel_bus),
    .dest_out(ls_dest)
  );

  // per-line event and summary terms
  genvar d;
  generate
    for (d = 0; d < NUM_DEST; d++) begin : g_dest
      // both groups may name the same line
      assign req[d] = tx_dest[d] | ls_dest[d];
      // a line that comes up marks its status bit
      assign rise[d] = s_reg.dest[d] & ~s_reg.dest_prev[d];
      // a read clears, but an edge in the same cycle survives
      assign kept[d] = (s_reg.status[d] & ~status_clear) | rise[d];
      assign active[d] = s_reg.status[d] & s_reg.mask[d];
    end
  endgenerate

  always_comb begin
    s_next = s_reg;
    s_next.dest = req;
    s_next.dest_prev = s_reg.dest;
    // read data stands one cycle, then falls back to zero
    s_next.rdata = route_pkg::UNMAPPED_READ;

    // write side
    unique case (wr_sel)
      REG_TX_LO: begin
        s_next.tx_lo = wdata_in;
      end

      REG_TX_HI: begin
        s_next.tx_hi = wdata_in;
      end

      REG_LS_0: begin
        s_next.ls0 = wdata_in;
      end

      REG_LS_1: begin
        s_next.ls1 = wdata_in;
      end

      REG_LS_2: begin
        s_next.ls2 = wdata_in;
      end

      REG_LS_3: begin
        s_next.ls3 = wdata_in;
      end

      REG_MASK: begin
        s_next.mask = wdata_in[NUM_DEST-1:0];
      end

      default: begin
        s_next.mask = s_reg.mask;
      end
    endcase

    // read side
    unique case (rd_sel)
      REG_TX_LO,
      REG_TX_HI,
      REG_LS_0,
      REG_LS_1,
      REG_LS_2,
      REG_LS_3: begin
        s_next.rdata = slot_word(rd_sel, s_reg);
      end

      REG_STATUS: begin
        s_next.rdata = widen(s_reg.status);
      end

      REG_MASK: begin
        s_next.rdata = widen(s_reg.mask);
      end

      REG_DEST: begin
        s_next.rdata = widen(s_reg.dest);
      end

      default: begin
        // unmapped reads return zero
        s_next.rdata = route_pkg::UNMAPPED_READ;
      end
    endcase
    s_next.status = kept;
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      // selectors come up as code 0, so every condition lands on line 0
      s_reg.tx_lo <= route_pkg::ROUTE_RESET;
      s_reg.tx_hi <= route_pkg::ROUTE_RESET;
      s_reg.ls0 <= route_pkg::ROUTE_RESET;
      s_reg.ls1 <= route_pkg::ROUTE_RESET;
      s_reg.ls2 <= route_pkg::ROUTE_RESET;
      s_reg.ls3 <= route_pkg::ROUTE_RESET;
      s_reg.dest <= '0;
      s_reg.dest_prev <= '0;
      s_reg.status <= route_pkg::STATUS_RESET;
      s_reg.mask <= route_pkg::MASK_RESET;
      s_reg.rdata <= route_pkg::UNMAPPED_READ;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata_out = s_reg.rdata;
  assign interrupt_destination_out = s_reg.dest;
  // level output: high while any unmasked status bit stands
  assign irq_out = |active;
endmodule : queue_interrupt_routing
`default_nettype wire

// ### route_sink.sv
`default_nettype none
module route_sink (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // destination lines in, sticky record out
  input wire logic [7:0] dest_in,
  output logic [7:0] seen_out
);
  // sticky so short pulses are not lost
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      seen_out <= 8'h00;
    end else begin
      seen_out <= seen_out | dest_in;
    end
  end
endmodule : route_sink
`default_nettype wire

// ### route_chk.sv
`default_nettype none
module route_chk #(
  parameter int unsigned NUM_TXQ = 16,
  parameter int unsigned NUM_LSC = 32,
  parameter int unsigned NUM_DEST = 8
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [route_pkg::ADDR_W-1:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic write_in,
  input wire logic read_in,
  input wire logic [31:0] rdata_out,
  input wire logic [NUM_TXQ-1:0] tx_pending_in,
  input wire logic [NUM_LSC-1:0] ls_pending_in,
  input wire logic [NUM_DEST-1:0] interrupt_destination_out,
  input wire logic irq_out
);
  logic [3:0] hist_reg;
  // pending history spans the sync and register delay
  always_ff @(posedge clk_in) hist_reg <= {hist_reg[2:0], |{tx_pending_in, ls_pending_in}};
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  a_rdata_idle: assert property (!read_in |=> rdata_out == 32'h0)
    else $error("read data outside answer cycle");
  a_reset_quiet: assert property (disable iff (1'b0) !resetn_in |=> !irq_out &&
    interrupt_destination_out == '0 && rdata_out == 32'h0) else $error("busy after reset");
  a_unmapped_zero: assert property (read_in && addr_in == 12'h000 |=> rdata_out == 32'h0)
    else $error("unmapped read not zero");
  a_sel_readback: assert property (write_in && addr_in == route_pkg::TX_ROUTE_LO_OFF ##1
    !write_in ##1 read_in && addr_in == route_pkg::TX_ROUTE_LO_OFF |=>
    rdata_out == $past(wdata_in, 3)) else $error("selector readback wrong");
  a_dest_cause: assert property (|interrupt_destination_out |-> |hist_reg)
    else $error("destination without pending");
  a_state_read: assert property (read_in && addr_in == route_pkg::DEST_STATE_OFF |=>
    rdata_out[7:0] == $past(interrupt_destination_out)) else $error("state read wrong");
  a_mask_off: assert property (write_in && addr_in == route_pkg::IRQ_MASK_OFF &&
    wdata_in[7:0] == 8'h00 ##1 !write_in |-> ##[0:1] !irq_out) else $error("masked irq high");
endmodule : route_chk
bind queue_interrupt_routing route_chk #(.NUM_TXQ(NUM_TXQ), .NUM_LSC(NUM_LSC),
  .NUM_DEST(NUM_DEST)) route_chk_inst (.*);
`default_nettype wire

// ### test_queue_interrupt_routing.sv
`default_nettype none
module test_queue_interrupt_routing;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 0, resetn_in = 0, wr = 0, rd = 0, irq;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [15:0] txp = 16'h0;
  logic [31:0] lsp = 32'h0;
  logic [7:0] dest, seen;
  int fails = 0, num_checks = 0;
  queue_interrupt_routing queue_interrupt_routing_inst (.clk_in(clk_in), .resetn_in(resetn_in),
    .addr_in(addr), .wdata_in(wdata), .write_in(wr), .read_in(rd), .rdata_out(rdata),
    .tx_pending_in(txp), .ls_pending_in(lsp), .interrupt_destination_out(dest), .irq_out(irq));
  route_sink route_sink_inst (.clk_in(clk_in), .resetn_in(resetn_in), .dest_in(dest),
    .seen_out(seen));
  initial begin
    forever #2 clk_in = ~clk_in;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk_in);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [11:0] a);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic pend(input logic [15:0] t, input logic [31:0] l);
    @(posedge clk_in);
    txp <= t;
    lsp <= l;
  endtask : pend
  // three edges of latency, two spare
  task automatic see(input logic [7:0] e);
    repeat (5) @(posedge clk_in);
    #1 chk(dest, e);
  endtask : see
  task automatic t_reset;
    for (int i = 0; i < 6; i++) begin
      rd_reg(12'h2d0 + 12'(i < 2 ? 4 * i : 8 + 4 * i));
      chk(d, route_pkg::ROUTE_RESET);
    end
    rd_reg(12'h000);
    chk(d, route_pkg::UNMAPPED_READ);
  endtask : t_reset
  task automatic t_codes;
    pend(16'h0001, 32'h0);
    for (int c = 0; c < 9; c++) begin
      wr_reg(route_pkg::TX_ROUTE_LO_OFF, 32'(c));
      see(c < 8 ? 8'h01 << c : 8'h00);
    end
    rd_reg(route_pkg::TX_ROUTE_LO_OFF);
    chk(d, 32'h8);
    wr_reg(route_pkg::TX_ROUTE_LO_OFF, 32'h0300_0000);
    rd_reg(route_pkg::TX_ROUTE_LO_OFF);
    chk(d, 32'h0300_0000);
    pend(16'h0040, 32'h0);
    see(8'h08);
    wr_reg(route_pkg::TX_ROUTE_HI_OFF, 32'h0000_0007);
    rd_reg(route_pkg::TX_ROUTE_HI_OFF);
    chk(d, 32'h7);
    pend(16'h0100, 32'h0);
    see(8'h80);
  endtask : t_codes
  task automatic t_ls;
    pend(16'h0, 32'h10);
    see(8'h01);
    wr_reg(route_pkg::LS_ROUTE_0_OFF, 32'h0005_0000);
    see(8'h20);
    wr_reg(route_pkg::LS_ROUTE_3_OFF, 32'h6000_0000);
    pend(16'h0, 32'h8000_0000);
    see(8'h40);
    rd_reg(route_pkg::DEST_STATE_OFF);
    chk(d, 32'h40);
  endtask : t_ls
  task automatic t_irq;
    wr_reg(route_pkg::IRQ_MASK_OFF, 32'h0);
    see(8'h40);
    chk(irq, 1'b0);
    wr_reg(route_pkg::IRQ_MASK_OFF, 32'hff);
    see(8'h40);
    chk(irq, 1'b1);
    pend(16'h0, 32'h0);
    see(8'h00);
    rd_reg(route_pkg::IRQ_STATUS_OFF);
    chk(d, 32'hff);
    see(8'h00);
    chk(irq, 1'b0);
  endtask : t_irq
  task automatic results;
    if (fails == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  initial begin
    repeat (16) @(posedge clk_in);
    resetn_in <= 1'b1;
    t_reset;
    t_codes;
    t_ls;
    t_irq;
    chk(seen, 8'hff);
    results;
  end
endmodule : test_queue_interrupt_routing
`default_nettype wire
